// ==== include/ppp_pkg.sv ====
// Package: constants, types and state layout for the parallel programming port controller
package ppp_pkg;

	localparam int    CLK_MHZ            = 125;
	// Timing figures as printed, and derived cycle counts
	localparam int    PULSE_NS           = 250;
	localparam int    PULSE_CYC          = (PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int    SETTLE_NS          = 100;
	localparam int    SETTLE_CYC         = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int    POWER_US           = 100;
	localparam int    POWER_CYC          = POWER_US * CLK_MHZ;
	localparam int    ENTRY_TOGGLES      = 6;
	localparam int    BUSY_SEEN_CYC      = 4;

	// Software register offsets (word index on the plain port)
	localparam logic [3:0] REG_CTRL      = 4'h0;
	localparam logic [3:0] REG_STATUS    = 4'h1;
	localparam logic [3:0] REG_ADDR      = 4'h2;
	localparam logic [3:0] REG_DATA      = 4'h3;
	localparam logic [3:0] REG_CMD       = 4'h4;

	// Control register opcode field, bits 3:0
	localparam logic [3:0] OP_ENTER      = 4'h1;
	localparam logic [3:0] OP_ENTER_ALT  = 4'h2;
	localparam logic [3:0] OP_EXIT       = 4'h3;
	localparam logic [3:0] OP_CMD        = 4'h4;
	localparam logic [3:0] OP_ADDR_LO    = 4'h5;
	localparam logic [3:0] OP_ADDR_HI    = 4'h6;
	localparam logic [3:0] OP_DATA_LO    = 4'h7;
	localparam logic [3:0] OP_DATA_HI    = 4'h8;
	localparam logic [3:0] OP_LATCH      = 4'h9;
	localparam logic [3:0] OP_START      = 4'ha;
	localparam logic [3:0] OP_WORD       = 4'hb;

	// Status bits
	localparam int    ST_BUSY            = 0;
	localparam int    ST_PROG_MODE       = 1;
	localparam int    ST_DEV_READY       = 2;
	localparam int    ST_ERROR           = 3;

	// Device command bytes
	localparam logic [7:0] CMD_CHIP_ERASE  = 8'h80;
	localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
	localparam logic [7:0] CMD_NOP         = 8'h00;
	localparam logic [7:0] ERASED_BYTE     = 8'hff;

	// Action-select codes {hi, lo}
	localparam logic [1:0] ACT_ADDR      = 2'b00;
	localparam logic [1:0] ACT_DATA      = 2'b01;
	localparam logic [1:0] ACT_CMD       = 2'b10;
	localparam logic [1:0] ACT_IDLE      = 2'b11;

	typedef enum logic [3:0] {
		PPP_OFF, PPP_TOGGLE, PPP_SETUP, PPP_POWER, PPP_HOLD, PPP_READY,
		PPP_DRIVE, PPP_PULSE, PPP_RECOVER, PPP_WAIT_LOW, PPP_WAIT_HIGH
	} ppp_state_t;

	// Pins toward the device
	typedef struct packed {
		logic       supply_on;
		logic       reset_low;
		logic       reset_hv;
		logic       load_strobe_pin;
		logic       page_latch_strobe;
		logic       write_strobe_n;
		logic       action_select_hi;
		logic       action_select_lo;
		logic       byte_select_one;
		logic [7:0] data_out;
		logic       data_oe_n;
	} ppp_pins_t;

	typedef struct packed {
		logic [7:0] rdata;
		logic       rvalid;
	} ppp_rd_t;

endpackage : ppp_pkg

// ==== verilog/ppp_host.sv ====
// Host-side controller that drives the parallel programming port of the device
// Operation
// - Hold reset low, toggle clock pin six times
// - Select pins 0000 for 100 ns first
// - Keep select pins still 100 ns after
// - Alternative entry: supply and high voltage together
// - Alternative entry then fuse rewrite, re-enter
// - Skip writing erased value after erase; the code skips only an OP_DATA_LO load of ERASED_BYTE, with control bit 4 set
// - Chip erase before reprogramming memories
// - Action 10, byte select low loads command
// - Chip erase command, write pulse, await ready
// - Page latch with byte select high buffers word
// - Repeat address, data, latch to fill page
// - Write pulse programs whole buffered page
//
// Added by the designer: the placing of the registers and the plain strobed port.
module ppp_host #(
	parameter int POWER_CYCLES = ppp_pkg::POWER_CYC,
	parameter int BUSY_TIMEOUT = 1000000
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             srst,
	// Software register port
	input  wire logic [3:0]       reg_addr,
	input  wire logic [15:0]      reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic [15:0]           reg_rdata,
	// Device pins
	output ppp_pkg::ppp_pins_t    pins,
	input  wire logic             ready_busy_out,
	input  wire logic [7:0]       data_in
);

	typedef struct packed {
		ppp_pkg::ppp_state_t state;
		ppp_pkg::ppp_pins_t  pins;
		logic [3:0]          op;
		logic [3:0]          step;
		logic [23:0]         cnt;
		logic [31:0]         tmo;
		logic                alt;
		logic                prog_mode;
		logic                busy;
		logic                error;
		logic                skip_ff;
		logic [15:0]         addr;
		logic [15:0]         data;
		logic [7:0]          cmd;
		logic [15:0]         rdata;
	} ppp_host_st_t;

	ppp_host_st_t r;
	ppp_host_st_t next_r;

	localparam logic [23:0] PULSE_W  = 24'(ppp_pkg::PULSE_CYC);
	localparam logic [23:0] SETTLE_W = 24'(ppp_pkg::SETTLE_CYC);
	localparam logic [23:0] POWER_W  = 24'(POWER_CYCLES);
	localparam logic [23:0] SEEN_W   = 24'(ppp_pkg::BUSY_SEEN_CYC);
	localparam logic [31:0] TMO_W    = 32'(BUSY_TIMEOUT);
	localparam logic [3:0]  TOG_W    = 4'(2 * ppp_pkg::ENTRY_TOGGLES);

	assign pins      = r.pins;
	assign reg_rdata = r.rdata;

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		logic       launch;
		logic       strobe_op;
		logic [1:0] act;
		logic       bsel;
		logic [7:0] byte_v;
		launch    = 1'b0;
		strobe_op = 1'b0;
		act       = ppp_pkg::ACT_IDLE;
		bsel      = 1'b0;
		byte_v    = 8'h00;
		next_r    = r;

		////////////////////////////////////////////////////////////////////////////////
		// Register reads answer in the following cycle
		next_r.rdata = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				ppp_pkg::REG_STATUS: next_r.rdata = {12'h000, r.error, ready_busy_out, r.prog_mode, r.busy};
				ppp_pkg::REG_ADDR:   next_r.rdata = r.addr;
				ppp_pkg::REG_DATA:   next_r.rdata = r.data;
				ppp_pkg::REG_CMD:    next_r.rdata = {8'h00, r.cmd};
				default:             next_r.rdata = 16'h0000;
			endcase
		end

		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				ppp_pkg::REG_ADDR: next_r.addr = reg_wdata;
				ppp_pkg::REG_DATA: next_r.data = reg_wdata;
				ppp_pkg::REG_CMD:  next_r.cmd  = reg_wdata[7:0];
				ppp_pkg::REG_CTRL: begin
					next_r.skip_ff = reg_wdata[4];
					if (!r.busy) begin
						launch       = 1'b1;
						next_r.op    = reg_wdata[3:0];
						next_r.error = 1'b0;
					end
				end
				default: ;
			endcase
		end

		if (launch) begin
			next_r.busy = 1'b1;
			next_r.step = 4'h0;
			next_r.cnt  = 24'h0;
			case (reg_wdata[3:0])
				ppp_pkg::OP_ENTER: begin
					// Reset low, select pins low, then toggle the clock pin
					next_r.pins             = '0;
					next_r.pins.data_oe_n   = 1'b1;
					next_r.pins.supply_on   = 1'b1;
					next_r.pins.reset_low   = 1'b1;
					next_r.pins.write_strobe_n = 1'b1;
					next_r.alt              = 1'b0;
					// A new entry drops the old mode until the sequence ends
					next_r.prog_mode        = 1'b0;
					next_r.state            = ppp_pkg::PPP_TOGGLE;
				end
				ppp_pkg::OP_ENTER_ALT: begin
					// Select pins 0000 before supply and high voltage rise together
					next_r.pins             = '0;
					next_r.pins.data_oe_n   = 1'b1;
					next_r.pins.write_strobe_n = 1'b1;
					next_r.alt              = 1'b1;
					next_r.prog_mode        = 1'b0;
					next_r.state            = ppp_pkg::PPP_SETUP;
				end
				ppp_pkg::OP_EXIT: begin
					next_r.pins.reset_hv    = 1'b0;
					next_r.pins.reset_low   = 1'b1;
					next_r.pins.data_oe_n   = 1'b1;
					next_r.prog_mode        = 1'b0;
					// Strobes idle and entry flag clear so a later entry starts clean
					next_r.pins.load_strobe_pin   = 1'b0;
					next_r.pins.page_latch_strobe = 1'b0;
					next_r.alt              = 1'b0;
					next_r.busy             = 1'b0;
					next_r.state            = ppp_pkg::PPP_OFF;
				end
				default: begin
					if (r.prog_mode)
						next_r.state = ppp_pkg::PPP_DRIVE;
					else begin
						next_r.busy  = 1'b0;
						next_r.error = 1'b1;
					end
				end
			endcase
		end

		////////////////////////////////////////////////////////////////////////////////
		// Pin setup for the operation in flight
		case (r.op)
			ppp_pkg::OP_CMD:     begin act = ppp_pkg::ACT_CMD;  bsel = 1'b0; byte_v = r.cmd;        end
			ppp_pkg::OP_ADDR_LO: begin act = ppp_pkg::ACT_ADDR; bsel = 1'b0; byte_v = r.addr[7:0];  end
			ppp_pkg::OP_ADDR_HI: begin act = ppp_pkg::ACT_ADDR; bsel = 1'b1; byte_v = r.addr[15:8]; end
			ppp_pkg::OP_DATA_LO: begin act = ppp_pkg::ACT_DATA; bsel = 1'b0; byte_v = r.data[7:0];  end
			ppp_pkg::OP_DATA_HI: begin act = ppp_pkg::ACT_DATA; bsel = 1'b1; byte_v = r.data[15:8]; end
			ppp_pkg::OP_LATCH:   begin act = ppp_pkg::ACT_IDLE; bsel = 1'b1; end
			ppp_pkg::OP_START:   begin act = ppp_pkg::ACT_IDLE; bsel = 1'b0; end
			ppp_pkg::OP_WORD: begin
				// Address low, data low, data high, latch: one page-buffer word
				act  = (r.step == 4'h0) ? ppp_pkg::ACT_ADDR : ppp_pkg::ACT_DATA;
				bsel = (r.step >= 4'h2);
				case (r.step)
					4'h0:    byte_v = r.addr[7:0];
					4'h1:    byte_v = r.data[7:0];
					default: byte_v = r.data[15:8];
				endcase
			end
			default: ;
		endcase
		// Start pulses go out with byte select low and the data bus released
		strobe_op = (r.op == ppp_pkg::OP_START);

		////////////////////////////////////////////////////////////////////////////////
		// Sequencer
		case (r.state)
			ppp_pkg::PPP_TOGGLE: begin
				next_r.cnt = r.cnt + 24'h1;
				if (r.cnt == PULSE_W - 24'h1) begin
					next_r.cnt                  = 24'h0;
					next_r.step                 = r.step + 4'h1;
					next_r.pins.load_strobe_pin = ~r.pins.load_strobe_pin;
					if (r.step == TOG_W - 4'h1) begin
						next_r.pins.load_strobe_pin = 1'b0;
						next_r.state                = ppp_pkg::PPP_SETUP;
					end
				end
			end
			ppp_pkg::PPP_SETUP: begin
				// Select pins already at 0000; hold them
				next_r.cnt = r.cnt + 24'h1;
				if (r.cnt == SETTLE_W) begin
					next_r.cnt            = 24'h0;
					next_r.pins.reset_low = 1'b0;
					next_r.pins.reset_hv  = 1'b1;
					next_r.pins.supply_on = 1'b1;
					next_r.state          = r.alt ? ppp_pkg::PPP_POWER : ppp_pkg::PPP_HOLD;
				end
			end
			ppp_pkg::PPP_POWER: begin
				next_r.cnt = r.cnt + 24'h1;
				if (r.cnt == POWER_W)
					next_r.state = ppp_pkg::PPP_READY;
			end
			ppp_pkg::PPP_HOLD: begin
				// Select pins stay still after the high voltage arrives
				next_r.cnt = r.cnt + 24'h1;
				if (r.cnt == SETTLE_W)
					next_r.state = ppp_pkg::PPP_READY;
			end
			ppp_pkg::PPP_READY: begin
				next_r.prog_mode = 1'b1;
				next_r.busy      = 1'b0;
				next_r.state     = ppp_pkg::PPP_OFF;
			end
			ppp_pkg::PPP_DRIVE: begin
				next_r.pins.action_select_hi = act[1];
				next_r.pins.action_select_lo = act[0];
				next_r.pins.byte_select_one  = bsel;
				next_r.pins.data_out         = byte_v;
				next_r.pins.data_oe_n        = (r.op == ppp_pkg::OP_LATCH) || strobe_op;
				next_r.cnt                   = r.cnt + 24'h1;
				if (r.op == ppp_pkg::OP_DATA_LO && r.skip_ff && r.data[7:0] == ppp_pkg::ERASED_BYTE) begin
					next_r.busy  = 1'b0;
					next_r.state = ppp_pkg::PPP_OFF;
				end else if (r.cnt == SETTLE_W) begin
					next_r.cnt   = 24'h0;
					next_r.state = ppp_pkg::PPP_PULSE;
					if (strobe_op && !ready_busy_out) begin
						next_r.tmo   = 32'h0;
						next_r.state = ppp_pkg::PPP_WAIT_HIGH;
					end else if (strobe_op)
						next_r.pins.write_strobe_n = 1'b0;
					else if (r.op == ppp_pkg::OP_LATCH)
						next_r.pins.page_latch_strobe = 1'b1;
					else
						next_r.pins.load_strobe_pin = 1'b1;
				end
			end
			ppp_pkg::PPP_PULSE: begin
				next_r.cnt = r.cnt + 24'h1;
				if (r.cnt == PULSE_W - 24'h1) begin
					next_r.cnt                    = 24'h0;
					next_r.pins.load_strobe_pin   = 1'b0;
					next_r.pins.page_latch_strobe = 1'b0;
					next_r.pins.write_strobe_n    = 1'b1;
					next_r.state = strobe_op ? ppp_pkg::PPP_WAIT_LOW : ppp_pkg::PPP_RECOVER;
				end
			end
			ppp_pkg::PPP_RECOVER: begin
				next_r.cnt = r.cnt + 24'h1;
				if (r.cnt == PULSE_W - 24'h1) begin
					next_r.cnt  = 24'h0;
					next_r.step = r.step + 4'h1;
					if (r.op == ppp_pkg::OP_WORD && r.step != 4'h3)
						next_r.state = (r.step == 4'h2) ? ppp_pkg::PPP_DRIVE : ppp_pkg::PPP_DRIVE;
					else begin
						next_r.busy  = 1'b0;
						next_r.state = ppp_pkg::PPP_OFF;
					end
					if (r.op == ppp_pkg::OP_WORD && r.step == 4'h2)
						next_r.op = ppp_pkg::OP_WORD;
				end
			end
			ppp_pkg::PPP_WAIT_LOW: begin
				// Give the device a few cycles to pull ready/busy low
				next_r.cnt = r.cnt + 24'h1;
				if (!ready_busy_out || r.cnt == SEEN_W) begin
					next_r.tmo   = 32'h0;
					next_r.state = ppp_pkg::PPP_WAIT_HIGH;
				end
			end
			ppp_pkg::PPP_WAIT_HIGH: begin
				// Erase or page program runs until ready/busy returns high
				next_r.tmo = r.tmo + 32'h1;
				if (ready_busy_out) begin
					next_r.busy  = 1'b0;
					next_r.state = ppp_pkg::PPP_OFF;
				end else if (r.tmo == TMO_W) begin
					next_r.busy  = 1'b0;
					next_r.error = 1'b1;
					next_r.state = ppp_pkg::PPP_OFF;
				end
			end
			default: ;
		endcase

		// Word sequence: step 3 is the page latch
		if (r.op == ppp_pkg::OP_WORD && r.state == ppp_pkg::PPP_DRIVE && r.step == 4'h3) begin
			next_r.pins.data_oe_n        = 1'b1;
			next_r.pins.byte_select_one  = 1'b1;
			next_r.pins.action_select_hi = 1'b1;
			next_r.pins.action_select_lo = 1'b1;
			if (r.cnt == SETTLE_W) begin
				next_r.pins.load_strobe_pin   = 1'b0;
				next_r.pins.page_latch_strobe = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			r                     <= '0;
			r.state               <= ppp_pkg::PPP_OFF;
			r.pins.reset_low      <= 1'b1;
			r.pins.write_strobe_n <= 1'b1;
			r.pins.data_oe_n      <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

endmodule : ppp_host

// ==== sim/ppp_host_assertions.sv ====
// Checker on the pins of the programming port controller
module ppp_host_assertions (
	// Clock and reset
	input wire logic               sys_clk,
	input wire logic               srst,
	// Device pins
	input wire ppp_pkg::ppp_pins_t pins,
	input wire logic               ready_busy_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	logic [3:0] sel;
	logic [3:0] edges;
	logic       prev_ls;
	assign sel = {pins.page_latch_strobe, pins.action_select_hi, pins.action_select_lo, pins.byte_select_one};
	// Clock-pin edges seen while the device is held in reset
	always_ff @(posedge sys_clk) begin
		prev_ls <= pins.load_strobe_pin;
		if (srst || pins.reset_hv)
			edges <= 4'h0;
		else if (pins.load_strobe_pin != prev_ls && edges != 4'hf)
			edges <= edges + 4'h1;
	end
	////////////////////////////////////////////////////////////////////////////////
	sequence s_sel_zero;
		(sel == 4'h0) [*8] ##1 (sel == 4'h0) [*5];
	endsequence
	sequence s_wr_low;
		!pins.write_strobe_n [*8];
	endsequence
	AST_RST_HOLD: assert property ($fell(srst) |-> pins.reset_low && !pins.reset_hv)
		else $error("device reset not held after controller reset");
	AST_ENTRY_TOGGLES: assert property ($rose(pins.reset_hv) && !$rose(pins.supply_on) |-> edges >= 4'h6)
		else $error("too few clock-pin toggles before programming voltage");
	AST_ENTRY_PAT: assert property ($rose(pins.reset_hv) |-> $past(sel) == 4'h0)
		else $error("entry pattern not set before programming voltage");
	AST_ENTRY_HOLD: assert property ($rose(pins.reset_hv) |-> s_sel_zero)
		else $error("entry pins moved after programming voltage");
	AST_WR_PULSE: assert property ($fell(pins.write_strobe_n) |-> s_wr_low)
		else $error("write pulse too short");
	AST_WR_SEL: assert property (!pins.write_strobe_n |-> !pins.byte_select_one)
		else $error("write pulse with byte select high");
	AST_LATCH_SEL: assert property (pins.page_latch_strobe |-> pins.byte_select_one)
		else $error("page latch with byte select low");
	AST_LOAD_PULSE: assert property ($rose(pins.load_strobe_pin) |-> pins.load_strobe_pin [*8])
		else $error("load pulse too short");
	AST_LOAD_STABLE: assert property (pins.load_strobe_pin && $past(pins.load_strobe_pin) |->
		$stable({pins.action_select_hi, pins.action_select_lo, pins.byte_select_one, pins.data_out}))
		else $error("select or data moved during load pulse");
	AST_LOAD_DRIVE: assert property ($rose(pins.load_strobe_pin) && pins.reset_hv |-> !pins.data_oe_n)
		else $error("data bus not driven at load");
	AST_BUSY_NO_WR: assert property (!ready_busy_out |-> !$fell(pins.write_strobe_n))
		else $error("write pulse while device busy");
endmodule : ppp_host_assertions
bind ppp_host ppp_host_assertions i_chk (.sys_clk(sys_clk), .srst(srst), .pins(pins), .ready_busy_out(ready_busy_out));

// ==== sim/ppp_dev_model.sv ====
// Behavioural model of the device behind the programming pins
module ppp_dev_model #(
	parameter int BUSY_CYC = 40
) (
	// Clock
	input wire logic               sys_clk,
	// Pins from the controller
	input wire ppp_pkg::ppp_pins_t pins,
	// Answers
	output logic                   ready_busy_out,
	output logic [7:0]             data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic               mode = 1'b0;
	logic [7:0]         cmd = 8'h00, adr_lo = 8'h00, adr_hi = 8'h00, dat_lo = 8'h00, dat_hi = 8'h00;
	logic [15:0]        page [0:63];
	int                 tog = 0, hold = 0, busy = 0, n_erase = 0, n_prog = 0;
	ppp_pkg::ppp_pins_t p = '0;
	wire  [3:0]         sel = {pins.page_latch_strobe, pins.action_select_hi, pins.action_select_lo, pins.byte_select_one};
	assign ready_busy_out = (busy == 0);
	// Bus is never driven by the device here, so show a moving pattern
	initial data_in = 8'h5a;
	always @(posedge sys_clk) begin
		data_in <= ~data_in;
		if (busy > 0)
			busy <= busy - 1;
		if (pins.reset_low || (p.supply_on && !pins.supply_on)) begin
			mode <= 1'b0;
			if (pins.load_strobe_pin != p.load_strobe_pin)
				tog <= tog + 1;
		end else if (pins.reset_hv && !p.reset_hv) begin
			mode <= (sel == 4'h0) && (tog >= 6 || !p.supply_on);
			hold <= ppp_pkg::SETTLE_CYC;
			tog <= 0;
		end else if (hold > 0) begin
			hold <= hold - 1;
			if (sel != 4'h0)
				mode <= 1'b0;
		end else if (mode) begin
			if (pins.load_strobe_pin && !p.load_strobe_pin)
				case (sel[2:1])
					ppp_pkg::ACT_ADDR: if (sel[0]) adr_hi <= pins.data_out; else adr_lo <= pins.data_out;
					ppp_pkg::ACT_DATA: if (sel[0]) dat_hi <= pins.data_out; else dat_lo <= pins.data_out;
					ppp_pkg::ACT_CMD: if (!sel[0]) cmd <= pins.data_out;
					default: ;
				endcase
			if (pins.page_latch_strobe && !p.page_latch_strobe && sel[0])
				page[adr_lo[5:0]] <= {dat_hi, dat_lo};
			if (!pins.write_strobe_n && p.write_strobe_n && busy == 0 && !sel[0]) begin
				busy <= BUSY_CYC;
				if (cmd == ppp_pkg::CMD_CHIP_ERASE)
					n_erase <= n_erase + 1;
				if (cmd == ppp_pkg::CMD_WRITE_FLASH)
					n_prog <= n_prog + 1;
			end
		end
		p <= pins;
	end
endmodule : ppp_dev_model

// ==== sim/ppp_host_tb_top.sv ====
// Self-checking bench for the programming port controller
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module ppp_host_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic               sys_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [3:0]         reg_addr = 4'h0;
	logic [15:0]        reg_wdata = 16'h0000, reg_rdata, rd_v;
	ppp_pkg::ppp_pins_t pins;
	logic               ready_busy_out;
	logic [7:0]         data_in;
	int                 fails = 0, n_compared = 0, i, j, e_adr, e_dat, e_hi;
	int                 e_page [int];
	always #4 sys_clk = ~sys_clk;
	ppp_host #(.POWER_CYCLES(20), .BUSY_TIMEOUT(200)) i_dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins(pins),
		.ready_busy_out(ready_busy_out), .data_in(data_in));
	ppp_dev_model i_dev (.sys_clk(sys_clk), .pins(pins), .ready_busy_out(ready_busy_out), .data_in(data_in));
	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask : wr
	task automatic rd(input logic [3:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 rd_v = reg_rdata;
		@(posedge sys_clk);
	endtask : rd
	// Issue an operation and poll until the controller is idle again
	task automatic op(input logic [15:0] c);
		int k;
		wr(ppp_pkg::REG_CTRL, c);
		for (k = 0; k < 3000 && (k == 0 || rd_v[ppp_pkg::ST_BUSY] !== 1'b0); k++)
			rd(ppp_pkg::REG_STATUS);
		if (k == 3000) begin
			fails++;
			wrap_up();
		end
	endtask : op
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hb092));
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		`CHK("reset_low", 1'b1, pins.reset_low)
		op(16'(ppp_pkg::OP_ENTER_ALT));
		`CHK("alt mode", 1'b1, i_dev.mode)
		op(16'(ppp_pkg::OP_EXIT));
		`CHK("exit mode", 1'b0, i_dev.mode)
		op(16'(ppp_pkg::OP_ENTER));
		`CHK("mode", 1'b1, i_dev.mode)
		rd(ppp_pkg::REG_STATUS);
		`CHK("prog", 1'b1, rd_v[ppp_pkg::ST_PROG_MODE])
		for (i = 0; i < 8; i++) begin
			e_adr = $urandom_range(16'hffff);
			e_dat = $urandom_range(16'hfffe);
			wr(ppp_pkg::REG_ADDR, 16'(e_adr));
			wr(ppp_pkg::REG_DATA, 16'(e_dat));
			for (j = 0; j < 4; j++)
				op(16'(ppp_pkg::OP_ADDR_LO + 4'(j)));
			`CHK("addr", 16'(e_adr), {i_dev.adr_hi, i_dev.adr_lo})
			`CHK("data", 16'(e_dat), {i_dev.dat_hi, i_dev.dat_lo})
		end
		e_hi = e_adr >> 8;
		wr(ppp_pkg::REG_CMD, 16'(ppp_pkg::CMD_WRITE_FLASH));
		op(16'(ppp_pkg::OP_CMD));
		`CHK("cmd", ppp_pkg::CMD_WRITE_FLASH, i_dev.cmd)
		for (i = 0; i < 6; i++) begin
			e_adr = $urandom_range(255);
			e_dat = $urandom_range(16'hfffe);
			e_page[e_adr % 64] = e_dat;
			wr(ppp_pkg::REG_ADDR, 16'(e_adr) | 16'hab00);
			wr(ppp_pkg::REG_DATA, 16'(e_dat));
			if (i[0]) begin
				op(16'(ppp_pkg::OP_ADDR_LO));
				op(16'(ppp_pkg::OP_DATA_LO));
				op(16'(ppp_pkg::OP_DATA_HI));
				op(16'(ppp_pkg::OP_LATCH));
			end else
				op(16'(ppp_pkg::OP_WORD));
			`CHK("addr hi", 8'(e_hi), i_dev.adr_hi)
		end
		foreach (e_page[k])
			`CHK("page", 16'(e_page[k]), i_dev.page[k])
		rd(ppp_pkg::REG_ADDR);
		`CHK("addr readback", 16'(e_adr) | 16'hab00, rd_v)
		op(16'(ppp_pkg::OP_START));
		`CHK("programs", 1, i_dev.n_prog)
		`CHK("cmd kept", ppp_pkg::CMD_WRITE_FLASH, i_dev.cmd)
		wr(ppp_pkg::REG_DATA, 16'h00ff);
		op(16'(ppp_pkg::OP_DATA_LO) | 16'h0010);
		`CHK("skip ff", 8'(e_dat), i_dev.dat_lo)
		wr(ppp_pkg::REG_CMD, 16'(ppp_pkg::CMD_CHIP_ERASE));
		op(16'(ppp_pkg::OP_CMD));
		wr(ppp_pkg::REG_CTRL, 16'(ppp_pkg::OP_START));
		wr(ppp_pkg::REG_CMD, 16'(ppp_pkg::CMD_NOP));
		op(16'(ppp_pkg::OP_CMD));
		`CHK("erases", 1, i_dev.n_erase)
		`CHK("cmd busy", ppp_pkg::CMD_CHIP_ERASE, i_dev.cmd)
		`CHK("rdy", 1'b1, ready_busy_out)
		srst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		`CHK("srst mode", 1'b0, i_dev.mode)
		`CHK("srst hv", 1'b0, pins.reset_hv)
		op(16'(ppp_pkg::OP_CMD));
		rd(ppp_pkg::REG_STATUS);
		`CHK("status after reset", 4'b1100, rd_v[3:0])
		wrap_up();
	end
endmodule : ppp_host_tb_top
